// ---- dv/ialc_chk_asserts.sv ----
// port assertions for the acknowledge controller
`timescale 1ns/10ps
module ialc_chk (
	// clock and reset
	input wire        mclk,
	input wire        rst_b,
	// sequencer and enables
	input wire        instr_done,
	input wire [2:0]  instr_class,
	input wire        ext_stack,
	input wire        gie,
	input wire        srv_en,
	input wire [7:0]  irq_mask_low,
	input wire [7:0]  irq_mask_high,
	// acknowledge side
	input wire        ack_std_q,
	input wire        ack_srv_q,
	input wire [3:0]  ack_src_q,
	input wire        busy_q,
	input wire        svc_done_q,
	input wire [14:0] server_select_bits,
	input wire [14:0] end_of_server_request_bits
);
	wire        ack = ack_std_q | ack_srv_q;
	reg  [12:0] len_q;
	reg         std_q;
	reg         ext_q;
	reg  [15:0] mk_q;
	reg  [14:0] sel_q;
	// service length, masks and selects one cycle back
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			len_q <= 13'h0;
			std_q <= 1'b0;
			ext_q <= 1'b0;
			mk_q <= 16'h0;
			sel_q <= 15'h0;
		end else begin
			len_q <= ack ? 13'h1 : len_q + {12'h0, busy_q};
			std_q <= ack ? ack_std_q : std_q;
			ext_q <= ack ? ext_stack : ext_q;
			mk_q <= {1'b1, irq_mask_high[6:0], irq_mask_low};
			sel_q <= server_select_bits;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	ack_at_end_a: assert property (
		ack |-> $past(instr_done) && $past(instr_class) == 3'h0)
		else $error("ack off a plain boundary");
	no_ack_busy_a: assert property (
		busy_q && $past(busy_q) |-> !ack)
		else $error("ack inside a service");
	end_pulse_a: assert property ($fell(busy_q) |-> svc_done_q)
		else $error("no finish pulse");
	call_len_a: assert property (
		$fell(busy_q) && std_q |-> len_q == (ext_q ? 13'd13 : 13'd11))
		else $error("call length wrong");
	mask_gate_a: assert property (
		ack && ack_src_q != 4'hf |-> mk_q[ack_src_q])
		else $error("masked source taken");
	std_gate_a: assert property (
		ack_std_q && ack_src_q != 4'hf |-> $past(gie))
		else $error("call while disabled");
	srv_gate_a: assert property (
		ack_srv_q |-> $past(srv_en) && sel_q[ack_src_q])
		else $error("server without select or enable");
	eos_gate_a: assert property (
		|(end_of_server_request_bits & ~$past(end_of_server_request_bits))
		|-> $past(gie))
		else $error("end request while disabled");
endmodule // ialc_chk

bind ialc_ctrl ialc_chk u_chk (
	.mclk(mclk), .rst_b(rst_b), .instr_done(instr_done),
	.instr_class(instr_class), .ext_stack(ext_stack), .gie(gie),
	.srv_en(srv_en), .irq_mask_low(irq_mask_low),
	.irq_mask_high(irq_mask_high), .ack_std_q(ack_std_q),
	.ack_srv_q(ack_srv_q), .ack_src_q(ack_src_q), .busy_q(busy_q),
	.svc_done_q(svc_done_q), .server_select_bits(server_select_bits),
	.end_of_server_request_bits(end_of_server_request_bits));

// ---- dv/ialc_seq.sv ----
// instruction sequencer model driving the controller
`timescale 1ns/10ps
module ialc_seq (
	// clock
	input wire        mclk,
	// length and class of instructions
	input wire [5:0]  len,
	input wire [2:0]  cls,
	// sequencer side
	output wire       instr_done,
	output reg  [5:0] instr_left,
	output wire [2:0] instr_class
);
	initial instr_left = 6'h1;
	// class valid only at completion, junk otherwise
	assign instr_done = instr_left == 6'h1;
	assign instr_class = instr_done ? cls : ~cls;
	// count state times down, reload at the end
	always @(posedge mclk)
		instr_left <= instr_done ? len : instr_left - 6'h1;
endmodule // ialc_seq

// ---- dv/interrupt_ack_latency_ctrl_test.sv ----
// directed bench for the acknowledge controller
`timescale 1ns/10ps
module interrupt_ack_latency_ctrl_test;
	reg         mclk = 1'b0;
	reg         rst_b = 1'b0;
	reg         ext = 1'b0;
	reg         gie = 1'b0;
	reg         sen = 1'b0;
	reg  [7:0]  mlo = 8'hdf;
	reg  [14:0] src = 15'h0;
	reg         nmi = 1'b0;
	reg         swr = 1'b0;
	reg  [3:0]  mode = 4'h2;
	reg  [7:0]  nx = 8'h2;
	reg         last = 1'b0;
	reg  [2:0]  cls = 3'h0;
	reg  [15:0] pk;
	reg         ty;
	wire        done, ast, asv, busy;
	wire [5:0]  left;
	wire [2:0]  icl;
	wire [3:0]  asrc;
	wire [7:0]  plo, phi;
	wire [14:0] sel, eos;
	integer     fails = 0, n_checks = 0, nack = 0, dn, bl, i, k;
	integer     ex [0:8] = '{37, 43, 49, 27, 30, 33, 21, 25, 20};
	ialc_seq seq (.mclk(mclk), .len(6'h14), .cls(cls),
		.instr_done(done), .instr_left(left), .instr_class(icl));
	ialc_ctrl dut (.mclk(mclk), .rst_b(rst_b), .instr_done(done),
		.instr_left(left), .instr_class(icl), .ext_stack(ext),
		.gie(gie), .srv_en(sen), .irq_mask_low(mlo),
		.irq_mask_high(8'h7f), .irq_src(src), .nmi_pin(nmi),
		.sel_wr(swr), .sel_wdata(15'h0004), .tcb_mode(mode),
		.tcb_xfers(nx), .tcb_last(last), .ack_std_q(ast),
		.ack_srv_q(asv), .ack_src_q(asrc), .busy_q(busy),
		.svc_done_q(), .irq_pending_low(plo), .irq_pending_high(phi),
		.server_select_bits(sel), .end_of_server_request_bits(eos));
	always #50 mclk = ~mclk;
	always @(posedge mclk) if (ast === 1'b1 || asv === 1'b1) nack = nack + 1;
	// -------------------------------------------
	// tasks
	// -------------------------------------------
	task chk(input [15:0] s, input [15:0] e, input [63:0] nm);
		begin
			n_checks = n_checks + 1;
			if (s !== e) begin
				fails = fails + 1;
				$display("ERROR %0s exp %h seen %h", nm, e, s);
			end
		end
	endtask
	// pulse sources while the count is one below a given value, class for that instruction
	task req(input [14:0] m, input [5:0] at, input [2:0] c);
		begin
			@(negedge mclk);
			while (left !== at) @(negedge mclk);
			@(posedge mclk);
			src <= m;
			cls <= c;
			@(posedge mclk);
			src <= 15'h0;
		end
	endtask
	// count completions up to the ack, then time the service
	task meas;
		begin
			dn = 0;
			bl = 0;
			k = 0;
			while (k < 400) begin
				@(negedge mclk);
				k = k + 1;
				if (ast === 1'b1 || asv === 1'b1) begin
					pk = {phi, plo};
					ty = asv;
					k = 400;
				end else if (done === 1'b1) begin
					dn = dn + 1;
					@(posedge mclk);
					cls <= 3'h0;
				end
			end
			while (busy === 1'b1) begin
				bl = bl + 1;
				@(negedge mclk);
			end
		end
	endtask
	task gap(input [63:0] nm);
		begin
			repeat (3) @(posedge done);
			$display("test %0s done", nm);
		end
	endtask
	task final_report;
		begin
			$display("checks %0d fails %0d", n_checks, fails);
			if (fails == 0 && n_checks > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	// -------------------------------------------
	// tests
	// -------------------------------------------
	initial begin
		repeat (16) @(posedge mclk);
		rst_b <= 1'b1;
		repeat (4) @(posedge mclk);
		req(15'h0228, 6'h14, 3'h0);
		gap("hold");
		chk(nack[15:0], 16'h0, "acks");
		chk({phi, plo}, 16'h0228, "pend");
		@(posedge mclk) gie <= 1'b1;
		meas;
		chk({asrc, ty, 3'h0, bl[7:0]}, 16'h900b, "std9");
		chk(pk, 16'h0028, "pclr");
		// no wait here: source 3 is taken two boundaries on
		$display("test std9 done");
		@(posedge mclk) ext <= 1'b1;
		meas;
		chk({asrc, ty, 3'h0, bl[7:0]}, 16'h300d, "std3");
		@(posedge mclk) ext <= 1'b0;
		gap("std3");
		for (i = 0; i < 7; i = i + 1) begin
			req(15'h0002, i < 6 ? 6'h14 : 6'h05, i < 6 ? i[2:0] : 3'h0);
			meas;
			chk(dn[15:0], i == 0 ? 16'h1 : 16'h2, "defer");
			gap("defer");
		end
		@(posedge mclk) gie <= 1'b0;
		@(posedge mclk) nmi <= 1'b1;
		meas;
		chk({12'h0, asrc}, 16'h000f, "nmi");
		@(posedge mclk) nmi <= 1'b0;
		gap("nmi");
		@(posedge mclk) swr <= 1'b1;
		@(posedge mclk) swr <= 1'b0;
		req(15'h0004, 6'h14, 3'h0);
		gap("gate");
		chk(nack[15:0], 16'h000a, "srvoff");
		@(posedge mclk) sen <= 1'b1;
		for (i = 0; i < 9; i = i + 1) begin
			if (i > 0) req(15'h0004, 6'h14, 3'h0);
			meas;
			chk({ty, 7'h0, bl[7:0]}, 16'h8000 | ex[i][15:0], "cost");
			@(posedge mclk) mode <= i < 7 ? i[3:0] + 4'h3 : 4'h5;
			nx <= i < 7 ? 8'h2 : 8'h0;
		end
		@(posedge mclk) last <= 1'b1;
		req(15'h0004, 6'h14, 3'h0);
		meas;
		gap("end0");
		chk({14'h0, sel[2], eos[2]}, 16'h0, "end0");
		@(posedge mclk) swr <= 1'b1;
		@(posedge mclk);
		swr <= 1'b0;
		gie <= 1'b1;
		req(15'h0004, 6'h14, 3'h0);
		meas;
		meas;
		chk({9'h0, ty, asrc, sel[2], eos[2]}, 16'h0008, "end1");
		gap("end1");
		final_report;
	end
	// watchdog, several times the expected run
	initial begin
		#2000000;
		fails = fails + 1;
		final_report;
	end
endmodule // interrupt_ack_latency_ctrl_test

// ---- inc/ialc_map.vh ----
// constants for the interrupt acknowledge and latency controller
// ----------------------------------------------------------------
// Functional notes
// [R1] acknowledge only at instruction completion
// [R2] late four-state request waits one more instruction
// [R3] standard ack clears pending, forces vector call
// [R4] call costs 11 states, plus 2 external
// [R5] server ack starts routine, no call overhead
// [R6] signed prefix defers ack past next instruction
// [R7] eight protected instructions defer next acknowledge
// [R8] read-modify-write logicals defer next acknowledge
// [R9] trap or unimplemented opcode blocks one instruction
// [R10] server cycle runs uninterrupted, whole block
// [R11] single mode 18/21/24 per transfer plus 1
// [R12] block mode 13/16/19 plus 7 per transfer
// [R13] scan mode 21 or 25 states
// [R14] set mask enables; nonmaskable bit ignored
// [R15] mask plus select picks service type
// [R16] server needs enable; standard needs enable
// [R17] server runs when disabled; no end request
// [R18] requests latch pending even when disabled
// [R19] count zero clears select, sets end request
// [R20] end request cleared when its vector taken
// [R21] nonmaskable over servers over standard
// [R22] pick highest eligible request at acknowledge
// ----------------------------------------------------------------
`ifndef IALC_MAP_VH
`define IALC_MAP_VH

// late window and call costs, in state times (one mclk each)
`define IALC_LATE_ST      6'd4
`define IALC_CALL_INT     13'd11
`define IALC_CALL_EXT_ADD 13'd2

// server cycle costs
`define IALC_SGL_RR    13'd18
`define IALC_SGL_MR    13'd21
`define IALC_SGL_MM    13'd24
`define IALC_SGL_ADD   13'd1
`define IALC_BLK_RR    13'd13
`define IALC_BLK_MR    13'd16
`define IALC_BLK_MM    13'd19
`define IALC_BLK_PER   13'd7
`define IALC_SCAN_RR   13'd21
`define IALC_SCAN_RM   13'd25

// service cost selectors
`define IALC_M_CALL_INT 4'h0
`define IALC_M_CALL_EXT 4'h1
`define IALC_M_SGL_RR   4'h2
`define IALC_M_SGL_MR   4'h3
`define IALC_M_SGL_MM   4'h4
`define IALC_M_BLK_RR   4'h5
`define IALC_M_BLK_MR   4'h6
`define IALC_M_BLK_MM   4'h7
`define IALC_M_SCAN_RR  4'h8
`define IALC_M_SCAN_RM  4'h9

// class of the completing instruction
`define IALC_C_PLAIN   3'h0
`define IALC_C_PREFIX  3'h1
`define IALC_C_PROT    3'h2
`define IALC_C_RMW     3'h3
`define IALC_C_TRAP    3'h4
`define IALC_C_UNIMP   3'h5

// nonmaskable source index
`define IALC_NMI_BIT   15

`endif

// ---- src/ialc_cost.v ----
// state-time counter for vector calls and server cycles
`timescale 1ns/10ps
`include "ialc_map.vh"
module ialc_cost (
	// clock and reset
	input  wire        mclk,
	input  wire        rst_n,
	// start request
	input  wire        start,
	input  wire [3:0]  mode,
	input  wire [7:0]  xfers,
	// status
	output reg         done_q
);
	reg  [12:0] cnt_q;
	reg  [12:0] cost;
	wire [12:0] n;
	wire [12:0] nb;

	assign n  = {5'h00, xfers};
	assign nb = (xfers == 8'h00) ? 13'h0001 : n; // [R12]

	// cost of the requested service
	always @* begin
		case (mode)
		`IALC_M_CALL_INT: cost = `IALC_CALL_INT; // [R4]
		`IALC_M_CALL_EXT: cost = `IALC_CALL_INT + `IALC_CALL_EXT_ADD;
		`IALC_M_SGL_RR: cost = `IALC_SGL_RR * n + `IALC_SGL_ADD; // [R11]
		`IALC_M_SGL_MR: cost = `IALC_SGL_MR * n + `IALC_SGL_ADD;
		`IALC_M_SGL_MM: cost = `IALC_SGL_MM * n + `IALC_SGL_ADD;
		`IALC_M_BLK_RR: cost = `IALC_BLK_RR + `IALC_BLK_PER * nb; // [R12]
		`IALC_M_BLK_MR: cost = `IALC_BLK_MR + `IALC_BLK_PER * nb;
		`IALC_M_BLK_MM: cost = `IALC_BLK_MM + `IALC_BLK_PER * nb;
		`IALC_M_SCAN_RR: cost = `IALC_SCAN_RR; // [R13]
		`IALC_M_SCAN_RM: cost = `IALC_SCAN_RM;
		default: cost = `IALC_CALL_INT;
		endcase
	end

	// count down; done stands in the last costed state time
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 13'h0000;
			done_q <= 1'b0;
		end else begin
			done_q <= (cnt_q == 13'h0002); // busy spans the cost
			if (start)
				cnt_q <= cost;
			else if (cnt_q != 13'h0000)
				cnt_q <= cnt_q - 13'h0001;
		end
	end
endmodule // ialc_cost

// ---- src/ialc_ctrl.v ----
// interrupt acknowledge, deferral and dispatch controller
`timescale 1ns/10ps
`include "ialc_map.vh"
module ialc_ctrl (
	// clock and reset
	input  wire        mclk,
	input  wire        rst_b,
	// instruction sequencer
	input  wire        instr_done,
	input  wire [5:0]  instr_left,
	input  wire [2:0]  instr_class,
	input  wire        ext_stack,
	// global enables
	input  wire        gie,
	input  wire        srv_en,
	// masks
	input  wire [7:0]  irq_mask_low,
	input  wire [7:0]  irq_mask_high,
	// request sources
	input  wire [14:0] irq_src,
	input  wire        nmi_pin,
	// select register write
	input  wire        sel_wr,
	input  wire [14:0] sel_wdata,
	// transfer control block of the chosen source
	input  wire [3:0]  tcb_mode,
	input  wire [7:0]  tcb_xfers,
	input  wire        tcb_last,
	// acknowledge and dispatch
	output reg         ack_std_q,
	output reg         ack_srv_q,
	output reg  [3:0]  ack_src_q,
	output reg         busy_q,
	output reg         svc_done_q,
	// status
	output reg  [7:0]  irq_pending_low,
	output reg  [7:0]  irq_pending_high,
	output reg  [14:0] server_select_bits,
	output reg  [14:0] end_of_server_request_bits
);
	// ------------------------------------------------------------
	// states
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_CALL = 2'b01;
	localparam ST_SRV  = 2'b10;

	// reset release
	reg         rst_s1_q;
	reg         rst_s2_q;
	wire        rst_n;

	// nonmaskable pin synchroniser
	reg         nmi_s1_q;
	reg         nmi_s2_q;
	reg         nmi_d1_q;
	wire        nmi_edge;

	// pending and eligibility
	wire [15:0] pend;
	reg  [15:0] elig_q;
	reg  [15:0] pend_d;
	reg  [14:0] eos_d;
	reg  [14:0] sel_d;
	wire [15:0] mask;
	wire [15:0] seen;
	wire [15:0] cand_std;
	wire [14:0] cand_srv;
	wire        late;

	// choice
	wire        pick_vld;
	wire        pick_srv;
	wire [3:0]  pick_idx;
	wire        take;
	wire        defer_now;

	// sequencing
	reg  [1:0]  st_q;
	reg  [1:0]  st_d;
	reg         defer_q;
	reg         last_q;
	reg         start;
	reg  [3:0]  cmode;
	wire        cost_done;

	// ------------------------------------------------------------
	// reset release through two flops
	// ------------------------------------------------------------
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end
	assign rst_n = rst_s2_q;

	// ------------------------------------------------------------
	// request detection
	// ------------------------------------------------------------
	// pin synchroniser, edge taken after second flop
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			nmi_s1_q <= 1'b0;
			nmi_s2_q <= 1'b0;
			nmi_d1_q <= 1'b0;
		end else begin
			nmi_s1_q <= nmi_pin;
			nmi_s2_q <= nmi_s1_q;
			nmi_d1_q <= nmi_s2_q;
		end
	end
	assign nmi_edge = nmi_s2_q & ~nmi_d1_q;

	assign pend = {irq_pending_high, irq_pending_low};
	assign seen = {nmi_edge, irq_src};

	// nonmaskable bit in the high mask has no effect
	assign mask = {1'b1, irq_mask_high[6:0], irq_mask_low}; // [R14]

	// requests in the last four states miss this boundary
	assign late = (instr_left <= `IALC_LATE_ST); // [R2]

	// eligible sets per service type
	assign cand_srv = elig_q[14:0] & pend[14:0] & mask[14:0] &
		server_select_bits & {15{srv_en}}; // [R15] [R16] [R17]
	assign cand_std[15] = elig_q[15] & pend[15]; // [R14]
	assign cand_std[14:0] = ((elig_q[14:0] & pend[14:0] &
		~server_select_bits) | end_of_server_request_bits) &
		mask[14:0] & {15{gie}}; // [R15] [R16] [R22]

	ialc_prio u_prio (
		.cand_std (cand_std),
		.cand_srv (cand_srv),
		.pick_vld (pick_vld),
		.pick_srv (pick_srv),
		.pick_idx (pick_idx)
	);

	// ------------------------------------------------------------
	// acknowledge decision
	// ------------------------------------------------------------
	// classes whose completion holds off the next acknowledge
	function defers;
		input [2:0] cls;
		begin
			case (cls)
			`IALC_C_PREFIX: defers = 1'b1; // [R6]
			`IALC_C_PROT:   defers = 1'b1; // [R7]
			`IALC_C_RMW:    defers = 1'b1; // [R8]
			`IALC_C_TRAP:   defers = 1'b1; // [R9]
			`IALC_C_UNIMP:  defers = 1'b1; // [R9]
			default:        defers = 1'b0;
			endcase
		end
	endfunction

	// boundary after a deferring instruction passes without ack
	assign defer_now = defers(instr_class);

	// only at a boundary, not deferred, not inside a service
	assign take = instr_done & (st_q == ST_IDLE) & ~defer_q & // [R1]
		~defer_now & pick_vld; // [R10] [R22]

	// ------------------------------------------------------------
	// next state and cost selection
	// ------------------------------------------------------------
	always @* begin
		st_d  = st_q;
		start = 1'b0;
		cmode = `IALC_M_CALL_INT;
		case (st_q)
		ST_IDLE: begin
			if (take) begin
				start = 1'b1;
				if (pick_srv) begin
					cmode = tcb_mode; // [R5]
					st_d  = ST_SRV;
				end else begin
					cmode = ext_stack ? `IALC_M_CALL_EXT :
						`IALC_M_CALL_INT; // [R4]
					st_d  = ST_CALL;
				end
			end
		end
		ST_CALL: begin
			if (cost_done)
				st_d = ST_IDLE;
		end
		ST_SRV: begin
			if (cost_done)
				st_d = ST_IDLE; // [R10]
		end
		default: st_d = ST_IDLE;
		endcase
	end

	ialc_cost u_cost (
		.mclk   (mclk),
		.rst_n  (rst_n),
		.start  (start),
		.mode   (cmode),
		.xfers  (tcb_xfers),
		.done_q (cost_done)
	);

	// ------------------------------------------------------------
	// pending, end-of-server and select bits
	// ------------------------------------------------------------
	always @* begin
		pend_d = pend;
		eos_d  = end_of_server_request_bits;
		sel_d  = server_select_bits;
		if (sel_wr)
			sel_d = sel_wdata;
		// clears first, so a new request wins below
		if (take) begin
			if (!pick_srv && pick_idx != 4'hf &&
			    end_of_server_request_bits[pick_idx[2:0] +
			    {pick_idx[3], 3'b000}])
				eos_d[pick_idx] = 1'b0; // [R20]
			else
				pend_d[pick_idx] = 1'b0; // [R3] [R5]
		end
		// count exhausted at the end of a server cycle
		if (st_q == ST_SRV && cost_done && last_q) begin
			sel_d[ack_src_q] = 1'b0; // [R19]
			if (gie)
				eos_d[ack_src_q] = 1'b1; // [R17] [R19]
		end
		// requests always latch, even when disabled
		pend_d = pend_d | seen; // [R18]
	end

	// ------------------------------------------------------------
	// sequencing registers
	// ------------------------------------------------------------
	// state, post-call deferral and end-of-count flag
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q    <= ST_IDLE;
			defer_q <= 1'b0;
			last_q  <= 1'b0;
		end else begin
			st_q <= st_d;
			// a finished call blocks the next boundary; set wins
			if (st_q == ST_CALL && cost_done)
				defer_q <= 1'b1;
			else if (instr_done)
				defer_q <= 1'b0;
			if (take)
				last_q <= tcb_last;
		end
	end

	// ------------------------------------------------------------
	// request bookkeeping registers
	// ------------------------------------------------------------
	// pending, select and end-of-server bits
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irq_pending_low            <= 8'h00;
			irq_pending_high           <= 8'h00;
			server_select_bits         <= 15'h0000;
			end_of_server_request_bits <= 15'h0000;
		end else begin
			{irq_pending_high, irq_pending_low} <= pend_d; // [R18]
			server_select_bits         <= sel_d;
			end_of_server_request_bits <= eos_d;
		end
	end

	// eligibility snapshot, takes no new bits inside the late window (bits still clear)
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			elig_q <= 16'h0000;
		else if (!late)
			elig_q <= pend_d; // [R2]
		else
			elig_q <= elig_q & pend_d;
	end

	// ------------------------------------------------------------
	// acknowledge outputs
	// ------------------------------------------------------------
	// pulses and levels seen by the sequencer
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ack_std_q  <= 1'b0;
			ack_srv_q  <= 1'b0;
			ack_src_q  <= 4'h0;
			busy_q     <= 1'b0;
			svc_done_q <= 1'b0;
		end else begin
			ack_std_q <= take & ~pick_srv; // [R3]
			ack_srv_q <= take & pick_srv; // [R5]
			if (take)
				ack_src_q <= pick_idx;
			busy_q     <= (st_d != ST_IDLE); // [R10]
			svc_done_q <= (st_q != ST_IDLE) & cost_done;
		end
	end
endmodule // ialc_ctrl

// ---- src/ialc_prio.v ----
// priority encoder for server and standard requests
`timescale 1ns/10ps
`include "ialc_map.vh"
module ialc_prio (
	// eligible requests
	input  wire [15:0] cand_std,
	input  wire [14:0] cand_srv,
	// chosen request
	output wire        pick_vld,
	output wire        pick_srv,
	output wire [3:0]  pick_idx
);
	// highest set bit of a 16-bit vector
	function [3:0] hi_idx;
		input [15:0] v;
		integer i;
		begin
			hi_idx = 4'h0;
			for (i = 0; i < 16; i = i + 1) begin
				if (v[i])
					hi_idx = i[3:0];
			end
		end
	endfunction

	wire nmi_req;
	wire srv_any;
	wire std_any;

	// nonmaskable first, then servers, then standard
	assign nmi_req  = cand_std[`IALC_NMI_BIT]; // [R21]
	assign srv_any  = |cand_srv;
	assign std_any  = |cand_std;
	assign pick_vld = std_any | srv_any; // [R22]
	assign pick_srv = ~nmi_req & srv_any; // [R21]
	assign pick_idx = pick_srv ? hi_idx({1'b0, cand_srv}) :
		hi_idx(cand_std);
endmodule // ialc_prio
